// ===== hdl/swap_stop_pkg.sv
// Package for the bank swap and stop execution block.
// Assumes a single 125 MHz core clock and an external fetch/decode front end.
package swap_stop_pkg;
  localparam logic [7:0] OP_BANK_SWAP   = 8'hD9;
  localparam logic [7:0] OP_STOP        = 8'h76;
  localparam logic       BANK_RESET     = 1'b0;
  localparam int unsigned REFRESH_NS    = 16;
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned REFRESH_CYC   = (REFRESH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] REFRESH_CNT    = 4'(REFRESH_CYC - 1);
  localparam logic [3:0] REFRESH_RESET  = 4'h0;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_STOP = 3'b010,
    ST_ANN  = 3'b100
  } stop_state_t;

  // Events reported back to the sequencer
  typedef struct packed {
    logic trap_brk;
    logic trap_priv;
    logic int_accept;
    logic done;
  } exec_evt_t;
endpackage

// ===== hdl/bank_swap_and_stop_exec.sv
// Execution logic for the bank swap and stop instructions.
// Assumes opcodes arrive as a one-cycle strobe with a valid byte; the
// sequencer honours o_fetch_hold and services traps and interrupts.
`timescale 1ns/1ns
// Function
// - Swap opcode complements the bank-select bit, exchanging three register pairs.
// - Stop opcode in system mode halts fetch and execution until interrupt or reset; outside it takes the privilege trap.
// - While stopped, processor state is held unchanged.
// - After interrupt service, execution resumes at the instruction after stop.
// - Memory refresh cycles keep running while stopped.
// - Bus requests are still granted while stopped.
// - Dedicated-pin mode asserts stopped output until interrupt or reset accepted.
// - Alternate bus modes issue a stop bus transaction instead of the pin.
// - Breakpoint-on-stop bit set makes a system-mode stop take the breakpoint trap instead.
module bank_swap_and_stop_exec (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_op_valid,
  input  wire logic [7:0]             i_op_byte,
  input  wire logic                   i_system_mode,
  input  wire logic                   i_brk_on_stop,
  input  wire logic                   i_pin_config,
  input  wire logic                   i_int_req,
  input  wire logic                   i_bus_req,
  output logic                        o_bank_sel,
  output logic                        o_fetch_hold,
  output logic                        o_stopped_n,
  output logic                        o_stop_cycle,
  output logic                        o_refresh,
  output logic                        o_bus_grant,
  output logic                        o_resume,
  output swap_stop_pkg::exec_evt_t    o_evt
);
  import swap_stop_pkg::*;

  stop_state_t state;
  stop_state_t next_state;
  logic        next_bank_sel;
  logic        next_fetch_hold;
  logic        next_stopped_n;
  logic        next_stop_cycle;
  logic        next_resume;
  exec_evt_t   next_evt;
  logic [3:0]  refresh_cnt;
  logic [3:0]  next_refresh_cnt;
  logic        next_refresh;
  logic        next_bus_grant;

  function automatic logic is_op(input logic v, input logic [7:0] b, input logic [7:0] op);
    is_op = v && (b == op);
  endfunction

  logic swap_hit;
  logic stop_hit;
  assign swap_hit = is_op(i_op_valid, i_op_byte, OP_BANK_SWAP);
  assign stop_hit = is_op(i_op_valid, i_op_byte, OP_STOP);

  // Instruction sequencing; swap changes only the bank bit, flags are never driven here
  always_comb begin
    next_state      = state;
    next_bank_sel   = o_bank_sel;
    next_fetch_hold = o_fetch_hold;
    next_stopped_n  = o_stopped_n;
    next_stop_cycle = 1'b0;
    next_resume     = 1'b0;
    next_evt        = '0;
    case (state)
      ST_RUN: begin
        if (swap_hit) begin
          next_bank_sel = ~o_bank_sel;
          next_evt.done = 1'b1;
        end else if (stop_hit) begin
          if (!i_system_mode) begin
            next_evt.trap_priv = 1'b1;
          end else if (i_brk_on_stop) begin
            next_evt.trap_brk = 1'b1;
          end else begin
            next_fetch_hold = 1'b1;
            if (i_pin_config) begin
              next_stopped_n = 1'b0;
              next_state     = ST_STOP;
            end else begin
              next_stop_cycle = 1'b1;
              next_state      = ST_ANN;
            end
          end
        end
      end
      ST_ANN: begin
        // One stop bus transaction has gone out; wait as in stop
        next_state = ST_STOP;
        if (i_int_req) begin
          next_fetch_hold    = 1'b0;
          next_resume        = 1'b1;
          next_evt.int_accept = 1'b1;
          next_state         = ST_RUN;
        end
      end
      ST_STOP: begin
        // Nothing but the wake check changes here, so context survives
        if (i_int_req) begin
          next_fetch_hold     = 1'b0;
          next_stopped_n      = 1'b1;
          next_resume         = 1'b1;
          next_evt.int_accept = 1'b1;
          next_state          = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state        <= ST_RUN;
      o_bank_sel   <= BANK_RESET;
      o_fetch_hold <= 1'b0;
      o_stopped_n  <= 1'b1;
      o_stop_cycle <= 1'b0;
      o_resume     <= 1'b0;
      o_evt        <= '0;
    end else begin
      state        <= next_state;
      o_bank_sel   <= next_bank_sel;
      o_fetch_hold <= next_fetch_hold;
      o_stopped_n  <= next_stopped_n;
      o_stop_cycle <= next_stop_cycle;
      o_resume     <= next_resume;
      o_evt        <= next_evt;
    end
  end

  // Refresh and bus grant run regardless of the stop state
  always_comb begin
    next_refresh     = 1'b0;
    next_refresh_cnt = refresh_cnt - 4'h1;
    if (refresh_cnt == 4'h0) begin
      next_refresh_cnt = REFRESH_CNT;
      next_refresh     = 1'b1;
    end
    next_bus_grant = i_bus_req;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      refresh_cnt <= REFRESH_RESET;
      o_refresh   <= 1'b0;
      o_bus_grant <= 1'b0;
    end else begin
      refresh_cnt <= next_refresh_cnt;
      o_refresh   <= next_refresh;
      o_bus_grant <= next_bus_grant;
    end
  end

  // Checks beside the logic; the pin check looks at the configuration seen
  // when the stop is taken, since the level may move while the block waits
  AST_SWAP_TOGGLE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RUN && swap_hit) |=> (o_bank_sel != $past(o_bank_sel)))
    else $error("bank select did not toggle");
  AST_STOP_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RUN && stop_hit && i_system_mode && !i_brk_on_stop) |=> o_fetch_hold)
    else $error("fetch not held on stop");
  AST_STOP_IGNORE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_STOP && !i_int_req) |=> !o_evt.done && !o_evt.trap_priv && !o_evt.trap_brk)
    else $error("opcode acted on while stopped");
  AST_STOP_KEEP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_STOP && !i_int_req) |=> $stable(o_bank_sel) && o_fetch_hold)
    else $error("state changed while stopped");
  AST_RESUME: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_STOP && i_int_req) |=> o_resume && !o_fetch_hold)
    else $error("no resume after interrupt");
  AST_ANN_WAKE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_ANN && i_int_req) |=> o_resume && !o_fetch_hold && o_evt.int_accept)
    else $error("no resume from announce cycle");
  AST_REFRESH: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_fetch_hold |-> ##[0:2] o_refresh)
    else $error("refresh missing while stopped");
  AST_REFRESH_GAP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_refresh |=> !o_refresh)
    else $error("refresh pulse too long");
  AST_GRANT: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_bus_req |=> o_bus_grant)
    else $error("bus request not granted");
  AST_GRANT_DROP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !i_bus_req |=> !o_bus_grant)
    else $error("bus granted without request");
  AST_PIN: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RUN && stop_hit && i_system_mode && !i_brk_on_stop && i_pin_config)
    |=> !o_stopped_n && !o_stop_cycle)
    else $error("stopped pin wrong");
  AST_PIN_KEEP: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!o_stopped_n && !i_int_req) |=> !o_stopped_n)
    else $error("stopped pin released early");
  AST_PIN_FREE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!o_stopped_n && i_int_req) |=> o_stopped_n && o_resume)
    else $error("stopped pin not released");
  AST_ANN: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RUN && stop_hit && i_system_mode && !i_brk_on_stop && !i_pin_config)
    |=> o_stop_cycle && o_stopped_n)
    else $error("stop transaction missing");
  AST_ANN_ONCE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_ANN && !i_int_req) |=> o_fetch_hold && !o_stop_cycle && o_stopped_n)
    else $error("stop transaction repeated");
  AST_BRK: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RUN && stop_hit && i_system_mode && i_brk_on_stop)
    |=> o_evt.trap_brk && !o_fetch_hold)
    else $error("breakpoint trap missing");
  AST_PRIV: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RUN && stop_hit && !i_system_mode) |=> o_evt.trap_priv)
    else $error("privilege trap missing");
  AST_PRIV_QUIET: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RUN && stop_hit && !i_system_mode) |=> !o_fetch_hold && o_stopped_n)
    else $error("privileged stop still stopped");
  AST_SWAP_QUIET: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (state == ST_RUN && swap_hit) |=> !o_fetch_hold && o_stopped_n && o_evt.done)
    else $error("swap disturbed other state");

  // Main scenarios
  COV_SWAP: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_RUN && swap_hit);
  COV_PIN_STOP: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    !o_stopped_n ##[1:10] o_resume);
  COV_ANN_STOP: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_stop_cycle ##[1:10] o_resume);
  COV_BRK: cover property (@(posedge i_core_clk) disable iff (!i_nrst) o_evt.trap_brk);
endmodule

// ===== dv/irq_bus_partner.sv
// Partner model: interrupt source and bus requester facing the block.
// Assumes one core clock; it changes its outputs at the falling edge only.
`timescale 1ns/1ns
module irq_bus_partner (
  input  wire logic       i_core_clk,
  input  wire logic       i_hold,
  input  wire logic       i_resume,
  input  wire logic [3:0] i_delay,
  output logic            o_int_req,
  output logic            o_bus_req
);
  int wait_cnt = 0;
  initial o_int_req = 1'b0;
  initial o_bus_req = 1'b0;
  // Interrupt rises a chosen time into a stop. Outside a stop it shows stray
  // pulses that a running block must ignore; one that lingers into a new
  // stop may wake it in its first cycle, announce cycle included
  always @(negedge i_core_clk) begin
    wait_cnt = i_hold ? wait_cnt + 1 : 0;
    if (!i_hold) o_int_req <= 1'($urandom_range(7) == 0);
    else if (wait_cnt == int'(i_delay)) o_int_req <= 1'b1;
    o_bus_req <= 1'($urandom_range(1));
  end
endmodule

// ===== dv/bank_swap_and_stop_exec_tb.sv
// Self-checking bench: random opcodes against a cycle model of the block.
// Assumes registered outputs one edge after the inputs are taken.
`timescale 1ns/1ns
module bank_swap_and_stop_exec_tb;
  import swap_stop_pkg::*;
  logic       i_core_clk = 1'b0, i_nrst = 1'b0, i_op_valid = 1'b0, i_system_mode = 1'b0;
  logic       i_brk_on_stop = 1'b0, i_pin_config = 1'b0, i_int_req, i_bus_req;
  logic [7:0] i_op_byte = 8'h00;
  logic [3:0] delay = 4'h2;
  logic       o_bank_sel, o_fetch_hold, o_stopped_n, o_stop_cycle, o_refresh, o_bus_grant;
  logic       o_resume, e_ref, e_bank, e_hold, e_stn, e_sc, e_res, e_grant, e_dk;
  exec_evt_t  o_evt, e_evt;
  int         fails = 0, n_tests = 0, st = 0, cyc = 0, rcyc = 0;

  bank_swap_and_stop_exec DUT (.i_core_clk, .i_nrst, .i_op_valid, .i_op_byte, .i_system_mode,
    .i_brk_on_stop, .i_pin_config, .i_int_req, .i_bus_req, .o_bank_sel, .o_fetch_hold,
    .o_stopped_n, .o_stop_cycle, .o_refresh, .o_bus_grant, .o_resume, .o_evt);
  irq_bus_partner peer (.i_core_clk, .i_hold(o_fetch_hold), .i_resume(o_resume),
    .i_delay(delay), .o_int_req(i_int_req), .o_bus_req(i_bus_req));

  always #4 i_core_clk = ~i_core_clk;

  // Reference model; st is 0 running, 1 announcing, 2 stopped
  always @(posedge i_core_clk) begin
    e_evt = '0; e_sc = '0; e_res = '0; e_dk = '1; e_grant = i_bus_req;
    // Refresh pulses once every REFRESH_CYC cycles, first one right after reset
    e_ref = i_nrst && (rcyc % REFRESH_CYC == 0);
    rcyc = i_nrst ? rcyc + 1 : 0;
    if (!i_nrst) begin
      e_bank = '0; e_hold = '0; e_stn = '1; e_grant = '0; st = 0;
    end else if (st != 0) begin
      // Announce cycle and stop both take the interrupt
      if (i_int_req) begin
        e_hold = '0; e_stn = '1; e_res = '1; e_evt.int_accept = '1; st = 0;
      end else st = 2;
    end else if (i_op_valid && i_op_byte == OP_BANK_SWAP) begin
      e_bank = !e_bank; e_evt.done = '1;
    end else if (i_op_valid && i_op_byte == OP_STOP) begin
      e_dk = '0; // Completion pulse of a stop is left open, so not judged
      if (!i_system_mode) e_evt.trap_priv = '1;
      else if (i_brk_on_stop) e_evt.trap_brk = '1;
      else begin
        e_hold = '1; e_stn = !i_pin_config; e_sc = !i_pin_config; st = i_pin_config ? 2 : 1;
      end
    end
  end

  task automatic chk(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Compare once per cycle, half a period after the edge; also bounds the run
  always @(negedge i_core_clk) begin
    cyc++;
    if (cyc > 1) begin
      chk("bank_sel", e_bank, o_bank_sel);
      chk("fetch_hold", e_hold, o_fetch_hold);
      chk("stopped_n", e_stn, o_stopped_n);
      chk("stop_cycle", e_sc, o_stop_cycle);
      chk("resume", e_res, o_resume);
      chk("int_accept", e_evt.int_accept, o_evt.int_accept);
      chk("trap_brk", e_evt.trap_brk, o_evt.trap_brk);
      chk("trap_priv", e_evt.trap_priv, o_evt.trap_priv);
      chk("bus_grant", e_grant, o_bus_grant);
      if (e_dk) chk("done", e_evt.done, o_evt.done);
      chk("refresh", e_ref, o_refresh);
    end
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end

  // Random opcodes, modes and wake delays; opcodes also arrive while stopped
  initial begin
    void'($urandom(32'h0000_62b3));
    repeat (5) @(negedge i_core_clk);
    i_nrst = 1'b1;
    for (int k = 0; k < 1200; k++) begin
      @(negedge i_core_clk);
      i_nrst = !(k inside {[600:601]});
      i_op_valid = 1'($urandom_range(1));
      case ($urandom_range(2))
        0: i_op_byte = OP_BANK_SWAP;
        1: i_op_byte = OP_STOP;
        default: i_op_byte = 8'($urandom);
      endcase
      i_system_mode = $urandom_range(3) != 0;
      i_brk_on_stop = $urandom_range(3) == 0;
      i_pin_config = 1'($urandom_range(1));
      if (o_fetch_hold !== 1'b1) delay = 4'($urandom_range(9, 1));
    end
    conclude();
  end
endmodule
